// ==== lcss_seq.sv ====
// Purpose: Charge state sequencer for a one-cell switch-mode charger.
// Assumes: Comparator results arrive as asynchronous levels.
// Notes: Analog loops act on charge_current_target; this block only steers.
// Notes on behaviour
// - Invalid input forces init except in thermal shutdown; suspended timer does so except in thermal shutdown or timer fault.
// - Init commands zero current, clears the timer, battery feeds system.
// - Init is left only once charger input is valid.
// - Disable pin low with valid input moves any state except timer fault and thermal shutdown to buck.
// - In buck the battery switch stays off unless supplement is needed.
// - Disable pin high leaves buck; enable changes only with valid input.
// - Battery below precharge threshold gives precharge current, even at 0V.
// - Precharge goes to trickle above threshold, fault after prequal time.
// - Between precharge and trickle thresholds, current is trickle current.
// - Trickle goes to fast CC above threshold, fault after prequal time.
// - Prequal config bit cleared skips trickle stage.
// - Fast CC limits current, goes CV at regulation, fault after time.
// - System load has priority; current may fall below target.
// - Fast CC reduces current when die exceeds regulation temperature.
// - CV holds voltage; top-off after low current for termination delay.
// - Top-off entered only from CV; done after top-off duration.
// - Top-off or done return to fast CC below restart level.
// - Done commands zero charge current.
// - Done to fast CC applies full target with no ramp.
// - Timer fault keeps charger off, fault output released, exit by replug.
// - Over-temperature forces thermal shutdown, charger off, from any state.
// - Input-ok low only with valid input and converter started.
`timescale 1ns/1ps
`include "lcss_defines.svh"
module lcss_seq
	import lcss_pkg::*;
#(
	parameter int PREQUAL_TICKS = `LCSS_PREQUAL_MS / `LCSS_TICK_MS,
	parameter int FAST_TICKS = `LCSS_FAST_MS / `LCSS_TICK_MS,
	parameter int TERM_TICKS = `LCSS_TERM_MS / `LCSS_TICK_MS,
	parameter int TOPOFF_TICKS = `LCSS_TOPOFF_MS / `LCSS_TICK_MS,
	parameter int TICK_CYC = `LCSS_TICK_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic input_valid_flag,
	input wire logic converter_started,
	input wire logic timer_suspend,
	input wire logic charge_disable_pin,
	input wire logic supplement_need,
	input wire logic batt_above_precharge,
	input wire logic batt_above_trickle,
	input wire logic batt_at_regulation,
	input wire logic batt_below_restart,
	input wire logic current_below_topoff,
	input wire logic die_over_regulation,
	input wire logic die_over_shutdown,
	input wire logic prequal_config_reg,
	output logic [1:0] charge_current_target,
	output logic thermal_reduce,
	output logic charger_on,
	output logic battery_system_switch,
	output logic input_ok_n,
	output logic fault_status_out,
	output logic fault_status_oe,
	output logic [3:0] charge_state
);
	localparam int NSYNC = 13;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] syn;
	logic valid_s;
	logic started_s;
	logic susp_s;
	logic dis_s;
	logic supp_s;
	logic above_pre_s;
	logic above_trk_s;
	logic at_reg_s;
	logic below_rst_s;
	logic low_cur_s;
	logic hot_reg_s;
	logic hot_shdn_s;
	logic prequal_s;
	lcss_state_type state_r;
	lcss_state_type state_nxt;
	logic [31:0] tick_cnt_r;
	logic tick;
	logic [31:0] dwell_r;
	logic [31:0] term_r;
	logic was_valid_r;
	logic prequal_en_r;
	logic cfg_caught_r;

	assign raw = {input_valid_flag, converter_started, timer_suspend,
		charge_disable_pin, supplement_need, batt_above_precharge,
		batt_above_trickle, batt_at_regulation, batt_below_restart,
		current_below_topoff, die_over_regulation, die_over_shutdown,
		prequal_config_reg};

	// Every comparator and pin input is synchronised before use.
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			lcss_sync u_sync (
				.clock(clock),
				.rst(rst),
				.din(raw[gi]),
				.dout(syn[gi])
			);
		end
	endgenerate

	assign {valid_s, started_s, susp_s, dis_s, supp_s, above_pre_s,
		above_trk_s, at_reg_s, below_rst_s, low_cur_s, hot_reg_s,
		hot_shdn_s, prequal_s} = syn;

	// Slow timebase divider: one-cycle tick per period.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= 32'h00000000;
		end else if (tick) begin
			tick_cnt_r <= 32'h00000000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h00000001;
		end
	end
	assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

	// The prequal option is captured once, after power-up settles;
	// a later change is only seen after the next reset.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prequal_en_r <= 1'b1;
			cfg_caught_r <= 1'b0;
		end else if (!cfg_caught_r && tick) begin
			prequal_en_r <= prequal_s;
			cfg_caught_r <= 1'b1;
		end
	end

	// Remembers input validity so a replug can be seen as a fall.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			was_valid_r <= 1'b0;
		end else begin
			was_valid_r <= valid_s;
		end
	end

	// Next-state logic; thermal shutdown outranks everything.
	always_comb begin
		state_nxt = state_r;
		if (hot_shdn_s) begin
			state_nxt = LCSS_TSHDN;
		end else if (state_r == LCSS_TSHDN) begin
			state_nxt = LCSS_INIT;
		end else if (!valid_s || susp_s) begin
			state_nxt = LCSS_INIT;
		end else if (!dis_s) begin
			state_nxt = LCSS_BUCK;
		end else begin
			case (state_r)
			LCSS_INIT, LCSS_BUCK: begin
				// Leaving init needs valid input, checked above.
				if (!above_pre_s) begin
					state_nxt = LCSS_PRE;
				end else if (!above_trk_s && prequal_en_r) begin
					state_nxt = LCSS_TRICKLE;
				end else if (!at_reg_s) begin
					state_nxt = LCSS_FAST_CC;
				end else begin
					state_nxt = LCSS_FAST_CV;
				end
			end
			LCSS_PRE: begin
				if (dwell_r >= 32'(PREQUAL_TICKS)) begin
					state_nxt = LCSS_TFAULT;
				end else if (above_pre_s) begin
					if (prequal_en_r) begin
						state_nxt = LCSS_TRICKLE;
					end else begin
						state_nxt = LCSS_FAST_CC;
					end
				end
			end
			LCSS_TRICKLE: begin
				if (dwell_r >= 32'(PREQUAL_TICKS)) begin
					state_nxt = LCSS_TFAULT;
				end else if (above_trk_s) begin
					state_nxt = LCSS_FAST_CC;
				end
			end
			LCSS_FAST_CC: begin
				if (dwell_r >= 32'(FAST_TICKS)) begin
					state_nxt = LCSS_TFAULT;
				end else if (at_reg_s) begin
					state_nxt = LCSS_FAST_CV;
				end
			end
			LCSS_FAST_CV: begin
				if (dwell_r >= 32'(FAST_TICKS)) begin
					state_nxt = LCSS_TFAULT;
				end else if (term_r >= 32'(TERM_TICKS)) begin
					state_nxt = LCSS_TOPOFF;
				end
			end
			LCSS_TOPOFF: begin
				if (below_rst_s) begin
					state_nxt = LCSS_FAST_CC;
				end else if (dwell_r >= 32'(TOPOFF_TICKS)) begin
					state_nxt = LCSS_DONE;
				end
			end
			LCSS_DONE: begin
				if (below_rst_s) begin
					state_nxt = LCSS_FAST_CC;
				end
			end
			LCSS_TFAULT: begin
				state_nxt = LCSS_TFAULT;
			end
			default: begin
				state_nxt = LCSS_INIT;
			end
			endcase
		end
		// Timer fault is held until the input falls away; the fall is
		// already routed to init above, so replug restarts charging.
		if (state_r == LCSS_TFAULT && !hot_shdn_s && valid_s && was_valid_r) begin
			state_nxt = LCSS_TFAULT;
		end
	end

	// State register.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= LCSS_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Dwell timer restarts on every state change except fast CC to CV; init holds it at zero.
	// CC and CV share one fast-charge budget, as both count against it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dwell_r <= 32'h00000000;
		end else if (state_nxt == LCSS_INIT || state_r == LCSS_INIT) begin
			dwell_r <= 32'h00000000;
		end else if (state_nxt != state_r &&
			!(state_r == LCSS_FAST_CC && state_nxt == LCSS_FAST_CV)) begin
			dwell_r <= 32'h00000000;
		end else if (tick) begin
			dwell_r <= dwell_r + 32'h00000001;
		end
	end

	// Termination qualifier: current must stay low without a break.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			term_r <= 32'h00000000;
		end else if (state_r != LCSS_FAST_CV || !low_cur_s) begin
			term_r <= 32'h00000000;
		end else if (tick) begin
			term_r <= term_r + 32'h00000001;
		end
	end

	// Current target per state, set in the same cycle as the state, so
	// the done-to-CC step is immediate with no ramp. Actual current may
	// sit below it, since analog loops serve the system load first.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			charge_current_target <= `LCSS_CUR_ZERO;
		end else begin
			case (state_nxt)
			LCSS_PRE: charge_current_target <= `LCSS_CUR_PRE;
			LCSS_TRICKLE: charge_current_target <= `LCSS_CUR_TRICKLE;
			LCSS_FAST_CC, LCSS_FAST_CV, LCSS_TOPOFF: begin
				charge_current_target <= `LCSS_CUR_FAST;
			end
			default: charge_current_target <= `LCSS_CUR_ZERO;
			endcase
		end
	end

	// Foldback request only in fast CC.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			thermal_reduce <= 1'b0;
		end else begin
			thermal_reduce <= (state_nxt == LCSS_FAST_CC) && hot_reg_s;
		end
	end

	// Charger enable and battery switch.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			charger_on <= 1'b0;
			battery_system_switch <= 1'b1;
		end else begin
			charger_on <= !(state_nxt inside {LCSS_INIT, LCSS_BUCK,
				LCSS_TFAULT, LCSS_TSHDN, LCSS_DONE});
			if (state_nxt == LCSS_INIT) begin
				battery_system_switch <= 1'b1;
			end else if (state_nxt == LCSS_BUCK) begin
				battery_system_switch <= supp_s;
			end else begin
				battery_system_switch <= !(state_nxt inside {LCSS_DONE,
					LCSS_TFAULT, LCSS_TSHDN}) || supp_s;
			end
		end
	end

	// Input-ok and fault pin; fault pin released in timer fault.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			input_ok_n <= 1'b1;
			fault_status_out <= 1'b0;
			fault_status_oe <= 1'b1;
			charge_state <= 4'h0;
		end else begin
			input_ok_n <= !(valid_s && started_s);
			fault_status_out <= 1'b0;
			fault_status_oe <= (state_nxt != LCSS_TFAULT);
			charge_state <= state_nxt;
		end
	end
endmodule // lcss_seq

// ==== lcss_defines.svh ====
// Purpose: Constants for the charge state sequencer.
// Assumes: 40 MHz system clock.
// Notes: Dwell times are counted in ticks of a 1 ms timebase.
`ifndef LCSS_DEFINES_SVH
`define LCSS_DEFINES_SVH
`define LCSS_CLK_HZ 40000000
`define LCSS_TICK_MS 1
// Cycles per timebase tick, derived from the clock rate.
`define LCSS_TICK_CYC ((`LCSS_CLK_HZ / 1000) * `LCSS_TICK_MS)
// Dwell limits in milliseconds (plain defaults).
`define LCSS_PREQUAL_MS 1800000
`define LCSS_FAST_MS 36000000
`define LCSS_TERM_MS 60000
`define LCSS_TOPOFF_MS 600000
// Current target codes.
`define LCSS_CUR_ZERO 2'h0
`define LCSS_CUR_PRE 2'h1
`define LCSS_CUR_TRICKLE 2'h2
`define LCSS_CUR_FAST 2'h3
`endif

// ==== lcss_pkg.sv ====
// Purpose: Types for the charge state sequencer.
// Assumes: Nothing beyond the defines header.
// Notes: States are Gray coded along the charging path.
package lcss_pkg;
	typedef enum logic [3:0] {
		LCSS_INIT = 4'h0,
		LCSS_PRE = 4'h1,
		LCSS_TRICKLE = 4'h3,
		LCSS_FAST_CC = 4'h2,
		LCSS_FAST_CV = 4'h6,
		LCSS_TOPOFF = 4'h7,
		LCSS_DONE = 4'h5,
		LCSS_BUCK = 4'h4,
		LCSS_TFAULT = 4'hC,
		LCSS_TSHDN = 4'hD
	} lcss_state_type;
endpackage

// ==== lcss_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to clock.
// Notes: Output changes once stages two and three agree.
`timescale 1ns/1ps
module lcss_sync (
	input wire logic clock,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// Stage one feeds only stage two to keep metastability contained.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Output follows only agreed values.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dout <= 1'b0;
		end else if (s2_r == s3_r) begin
			dout <= s3_r;
		end
	end
endmodule // lcss_sync

// ==== lcss_seq_checker.sv ====
// Purpose: Port assertions for the charge state sequencer.
// Assumes: A level change reaches the state within eight cycles.
// Notes: Bound to every sequencer instance.
`timescale 1ns/1ps
module lcss_seq_checker
	import lcss_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic input_valid_flag,
	input wire logic timer_suspend,
	input wire logic charge_disable_pin,
	input wire logic supplement_need,
	input wire logic die_over_shutdown,
	input wire logic [1:0] charge_current_target,
	input wire logic charger_on,
	input wire logic battery_system_switch,
	input wire logic input_ok_n,
	input wire logic fault_status_oe,
	input wire logic [3:0] charge_state
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Eight cycles covers the synchroniser plus the state register.
	sequence s_gone;
		(!input_valid_flag && !die_over_shutdown)[*8];
	endsequence
	sequence s_off_req;
		(input_valid_flag && !charge_disable_pin && !die_over_shutdown
			&& !timer_suspend)[*8];
	endsequence
	sequence s_topoff_in;
		charge_state == LCSS_TOPOFF && $past(charge_state) != LCSS_TOPOFF;
	endsequence
	// Init, precharge, trickle, fast CC and done are tied to their current codes; init and buck to their switch setting.
	AST_INIT_ON_LOSS: assert property (s_gone |-> charge_state inside
		{LCSS_INIT, LCSS_TSHDN}) else $error("no init after input loss");
	AST_INIT_IDLE: assert property (charge_state == LCSS_INIT |->
		charge_current_target == 2'h0 && battery_system_switch)
		else $error("init not idle");
	AST_BUCK_ENTRY: assert property (s_off_req |->
		charge_state == LCSS_BUCK) else $error("no buck on disable");
	AST_BUCK_SWITCH: assert property ((charge_state == LCSS_BUCK
		&& !supplement_need)[*8] |-> !battery_system_switch)
		else $error("switch on in buck");
	AST_PRE_CUR: assert property (charge_state == LCSS_PRE |->
		charge_current_target == 2'h1) else $error("bad precharge code");
	AST_TRICKLE_CUR: assert property (charge_state == LCSS_TRICKLE |->
		charge_current_target == 2'h2) else $error("bad trickle code");
	AST_CC_CUR: assert property (charge_state == LCSS_FAST_CC |->
		charge_current_target == 2'h3) else $error("bad fast code");
	AST_TOPOFF_FROM_CV: assert property (s_topoff_in |->
		$past(charge_state) == LCSS_FAST_CV) else $error("bad top-off entry");
	AST_DONE_ZERO: assert property (charge_state == LCSS_DONE |->
		charge_current_target == 2'h0) else $error("current in done");
	AST_FAULT_OFF: assert property (charge_state == LCSS_TFAULT |->
		!charger_on && !fault_status_oe) else $error("fault not off");
	AST_SHDN_OFF: assert property (charge_state == LCSS_TSHDN |->
		!charger_on) else $error("charger on in shutdown");
	AST_OK_N_OFF: assert property ((!input_valid_flag)[*8] |->
		input_ok_n) else $error("input ok without input");
endmodule // lcss_seq_checker

bind lcss_seq lcss_seq_checker chk_u (.clock(clock), .rst(rst),
	.input_valid_flag(input_valid_flag), .timer_suspend(timer_suspend),
	.charge_disable_pin(charge_disable_pin), .charger_on(charger_on),
	.supplement_need(supplement_need), .die_over_shutdown(die_over_shutdown),
	.charge_current_target(charge_current_target), .input_ok_n(input_ok_n),
	.battery_system_switch(battery_system_switch), .charge_state(charge_state),
	.fault_status_oe(fault_status_oe));

// ==== lcss_far_model.sv ====
// Purpose: Cell and host model on the far side of the sequencer.
// Assumes: Zone 0 is a flat or 0 V cell, 3 is at regulation.
// Notes: The host moves the disable pin only while input-ok is low.
`timescale 1ns/1ps
module lcss_far_model (
	input wire logic clock,
	input wire logic [1:0] zone,
	input wire logic want_charge,
	input wire logic input_ok_n,
	output logic batt_above_precharge,
	output logic batt_above_trickle,
	output logic batt_at_regulation,
	output logic batt_below_restart,
	output logic charge_disable_pin
);
	logic pin_r = 1'b1;
	// Comparators follow the cell voltage zone.
	assign batt_above_precharge = (zone >= 2'h1);
	assign batt_above_trickle = (zone >= 2'h2);
	assign batt_at_regulation = (zone == 2'h3);
	assign batt_below_restart = (zone != 2'h3);
	assign charge_disable_pin = pin_r;
	// A request is held back while input-ok is high, as the pin is ignored.
	always @(negedge clock) begin
		if (!input_ok_n) begin
			pin_r <= want_charge;
		end
	end
endmodule // lcss_far_model

// ==== lcss_seq_tb_top.sv ====
// Purpose: Self-checking bench for the charge state sequencer.
// Assumes: Short dwell parameters; one tick is ten cycles.
// Notes: Inputs move on the falling edge, away from the sampling edge.
`timescale 1ns/1ps
module lcss_seq_tb_top;
	import lcss_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic valid = 1'b0, started = 1'b1, susp = 1'b0, supp = 1'b0;
	logic cur_low = 1'b0, hot = 1'b0, shdn = 1'b0, cfg = 1'b1, want = 1'b1;
	logic [1:0] zone = 2'h0;
	logic pre, trk, at_reg, restart, dis, thr, chg_on, sw, ok_n, f_out, f_oe;
	logic [1:0] tgt;
	logic [3:0] st;
	int miscompares = 0;
	int n_compared = 0;
	initial begin
		forever #12.5 clock = ~clock;
	end
	lcss_seq #(.PREQUAL_TICKS(4), .FAST_TICKS(20), .TERM_TICKS(3),
		.TOPOFF_TICKS(5), .TICK_CYC(10)) dut_u (.clock(clock), .rst(rst),
		.input_valid_flag(valid), .converter_started(started),
		.timer_suspend(susp), .charge_disable_pin(dis),
		.supplement_need(supp), .batt_above_precharge(pre),
		.batt_above_trickle(trk), .batt_at_regulation(at_reg),
		.batt_below_restart(restart), .current_below_topoff(cur_low),
		.die_over_regulation(hot), .die_over_shutdown(shdn),
		.prequal_config_reg(cfg), .charge_current_target(tgt),
		.thermal_reduce(thr), .charger_on(chg_on),
		.battery_system_switch(sw), .input_ok_n(ok_n),
		.fault_status_out(f_out), .fault_status_oe(f_oe), .charge_state(st));
	lcss_far_model far_u (.clock(clock), .zone(zone), .want_charge(want),
		.input_ok_n(ok_n), .batt_above_precharge(pre),
		.batt_above_trickle(trk), .batt_at_regulation(at_reg),
		.batt_below_restart(restart), .charge_disable_pin(dis));
	// One closing point so the verdict is printed once.
	task automatic wrap_up();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait; running out is a mismatch and ends the run.
	task automatic wait_st(input logic [3:0] code, input int bound);
		int i;
		for (i = 0; i < bound && st !== code; i++) @(negedge clock);
		check(st, code);
		if (st !== code) wrap_up();
	endtask
	task automatic do_reset(input logic c);
		cfg = c;
		rst = 1'b1;
		repeat (5) @(negedge clock);
		rst = 1'b0;
	endtask
	// Flat cell through every charging stage to done and back.
	task automatic s_path();
		valid = 1'b1;
		wait_st(LCSS_PRE, 20);
		check(4'(tgt), 4'h1);
		check(4'(ok_n), 4'h0);
		zone = 2'h1;
		wait_st(LCSS_TRICKLE, 20);
		check(4'(tgt), 4'h2);
		zone = 2'h2;
		wait_st(LCSS_FAST_CC, 20);
		check(4'(tgt), 4'h3);
		hot = 1'b1;
		repeat (8) @(negedge clock);
		check(4'(thr), 4'h1);
		hot = 1'b0;
		zone = 2'h3;
		wait_st(LCSS_FAST_CV, 20);
		check(4'(thr), 4'h0);
		cur_low = 1'b1;
		repeat (20) @(negedge clock);
		check(st, LCSS_FAST_CV);
		wait_st(LCSS_TOPOFF, 40);
		repeat (40) @(negedge clock);
		check(st, LCSS_TOPOFF);
		wait_st(LCSS_DONE, 40);
		zone = 2'h2;
		wait_st(LCSS_FAST_CC, 20);
		check(4'(tgt), 4'h3);
		cur_low = 1'b0;
	endtask
	// Input loss, then a stuck precharge running into the timer fault.
	task automatic s_fault();
		valid = 1'b0;
		zone = 2'h0;
		wait_st(LCSS_INIT, 20);
		check({1'h0, tgt, sw}, 4'h1);
		// Keep the input away long enough for the loss assertions to see it.
		repeat (10) @(negedge clock);
		check(4'(ok_n), 4'h1);
		check(st, LCSS_INIT);
		valid = 1'b1;
		wait_st(LCSS_TFAULT, 90);
		check({2'h0, chg_on, f_oe}, 4'h0);
		check(4'(f_out), 4'h0);
		repeat (30) @(negedge clock);
		check(st, LCSS_TFAULT);
		valid = 1'b0;
		wait_st(LCSS_INIT, 20);
		valid = 1'b1;
		zone = 2'h2;
		wait_st(LCSS_FAST_CC, 20);
	endtask
	// Host disables charging, supplement needs the battery, then resumes.
	task automatic s_buck();
		want = 1'b0;
		wait_st(LCSS_BUCK, 20);
		check(4'(sw), 4'h0);
		// Dwell in buck without supplement so the switch assertion engages.
		repeat (10) @(negedge clock);
		check(4'(sw), 4'h0);
		supp = 1'b1;
		repeat (8) @(negedge clock);
		check(4'(sw), 4'h1);
		supp = 1'b0;
		want = 1'b1;
		wait_st(LCSS_FAST_CC, 20);
	endtask
	// Shutdown outranks input loss; then suspend holds init and a stopped switcher keeps input-ok high.
	task automatic s_therm();
		shdn = 1'b1;
		wait_st(LCSS_TSHDN, 20);
		valid = 1'b0;
		repeat (8) @(negedge clock);
		check(st, LCSS_TSHDN);
		shdn = 1'b0;
		wait_st(LCSS_INIT, 20);
		valid = 1'b1;
		susp = 1'b1;
		started = 1'b0;
		repeat (10) @(negedge clock);
		check({3'h0, ok_n}, 4'h1);
		check(st, LCSS_INIT);
		susp = 1'b0;
		started = 1'b1;
	endtask
	// With trickle disabled at reset the cell goes from precharge straight to fast charge.
	task automatic s_skip();
		zone = 2'h0;
		do_reset(1'b0);
		wait_st(LCSS_PRE, 20);
		repeat (15) @(negedge clock);
		zone = 2'h1;
		wait_st(LCSS_FAST_CC, 20);
	endtask
	initial begin
		do_reset(1'b1);
		s_path();
		s_fault();
		s_buck();
		s_therm();
		s_skip();
		wrap_up();
	end
endmodule // lcss_seq_tb_top
